// *** design/fbs_pkg.sv ***
/*
  Shared constants and types of the fieldbus slave status and cycle block:
  register map, field positions, reset values, indicator timing.
  Assumes a 125 MHz system clock.
*/
package fbs_pkg;
  localparam int unsigned CLK_KHZ = 125000;
  localparam int unsigned CLK_NS = 1000000 / CLK_KHZ;
  // indicator timing in milliseconds, then in clock cycles
  localparam int unsigned BLINK_MS = 200;
  localparam int unsigned PAUSE_MS = 1000;
  localparam int unsigned FLICKER_MS = 50;
  localparam int unsigned BLINK_CYC = BLINK_MS * CLK_KHZ;
  localparam int unsigned PAUSE_CYC = PAUSE_MS * CLK_KHZ;
  localparam int unsigned FLICKER_CYC = FLICKER_MS * CLK_KHZ;
  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_MIN_CYCLE = 8'h08;
  localparam logic [7:0] REG_MOD_PERIOD = 8'h0c;
  localparam logic [7:0] REG_OUT_BASE = 8'h10;
  localparam logic [7:0] REG_SAFE_BASE = 8'h30;
  // control fields
  localparam int unsigned CTRL_STATE_LSB = 0;
  localparam int unsigned CTRL_SYNC_BIT = 8;
  localparam int unsigned CTRL_FAULT_LSB = 16;
  // fault bit positions inside the fault field
  localparam int unsigned FLT_CFG = 0;
  localparam int unsigned FLT_EMERG = 1;
  localparam int unsigned FLT_APP_WD = 2;
  localparam int unsigned FLT_PDI_WD = 3;
  localparam int unsigned FLT_BOOT = 4;
  // status fields
  localparam int unsigned STAT_STATE_LSB = 0;
  localparam int unsigned STAT_RUN_LSB = 4;
  localparam int unsigned STAT_CYCERR_BIT = 8;
  localparam int unsigned STAT_SAFE_BIT = 9;
  localparam int unsigned STAT_FAULT_LSB = 12;
  // reset values
  localparam logic [31:0] MOD_PERIOD_RST = 32'h0000_0400;
  localparam logic [31:0] MIN_CYCLE_RST = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_INIT, ST_PREOP, ST_SAFEOP, ST_OP, ST_BOOT
  } fbs_state_t;

  typedef enum logic [2:0] {
    PAT_OFF, PAT_SOLID, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE, PAT_FLICKER
  } fbs_pat_t;
endpackage

// *** design/fbs_sync3.sv ***
/*
  Three-stage synchroniser for one pin level, with agreement filter.
  Assumes the input is asynchronous to clk_i.
*/
`timescale 1ns/10ps
module fbs_sync3 (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic pin_i,
  output logic lvl_o
);
  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic lvl;
  } fbs_sync_st_t;

  fbs_sync_st_t s, n;

  always_comb begin
    n = s;
    n.s1 = pin_i;
    n.s2 = s.s1;
    n.s3 = s.s2;
    // a change counts only once the two later stages agree
    if (s.s2 == s.s3) begin
      n.lvl = s.s3;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign lvl_o = s.lvl;
endmodule

// *** design/fbs_blink.sv ***
/*
  Indicator pattern generator: off, solid, blink, single and double flash
  with pause, flicker. Restarts the pattern, lit unless off, whenever the mode changes.
*/
`timescale 1ns/10ps
module fbs_blink
  import fbs_pkg::*;
#(
  parameter int unsigned BLINK_C = BLINK_CYC,
  parameter int unsigned PAUSE_C = PAUSE_CYC,
  parameter int unsigned FLICKER_C = FLICKER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input fbs_pat_t mode_i,
  output logic ind_o
);
  if (FLICKER_C < 1 || FLICKER_C >= BLINK_C || PAUSE_C < 1) begin // RL19
    $error("fbs_blink: flicker must be faster than blink");
  end

  typedef struct packed {
    fbs_pat_t mode;
    logic [31:0] cnt;
    logic [1:0] phase;
    logic led;
  } fbs_blink_st_t;

  fbs_blink_st_t s, n;
  logic [31:0] len;

  always_comb begin
    case (s.mode)
      PAT_FLICKER: len = FLICKER_C;
      PAT_SINGLE: len = (s.phase == 2'd1) ? PAUSE_C : BLINK_C;
      PAT_DOUBLE: len = (s.phase == 2'd3) ? PAUSE_C : BLINK_C;
      default: len = BLINK_C;
    endcase
  end

  always_comb begin
    n = s;
    if (mode_i != s.mode) begin
      n.mode = mode_i;
      n.cnt = '0;
      n.phase = '0;
      n.led = (mode_i != PAT_OFF);
    end else begin
      case (s.mode)
        PAT_OFF: n.led = 1'b0;
        PAT_SOLID: n.led = 1'b1;
        default: begin
          if (s.cnt >= len - 32'd1) begin
            n.cnt = '0;
            case (s.mode)
              PAT_SINGLE: begin
                n.phase = {1'b0, ~s.phase[0]};
                n.led = s.phase[0];
              end
              PAT_DOUBLE: begin
                n.phase = s.phase + 2'd1;
                n.led = s.phase[0];
              end
              default: n.led = ~s.led;
            endcase
          end else begin
            n.cnt = s.cnt + 32'd1;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign ind_o = s.led;
endmodule

// *** design/fbs_status_cycle.sv ***
/*
  Fieldbus slave status and cycle control: slave state, indicator
  patterns, safe-state outputs and conversion cycle sequencing, reached
  over a classic Wishbone slave. Assumes cycle_sync_i is an asynchronous
  pin from the distributed clock unit.
*/
// Operation
// [RL1] INIT state keeps run indicator dark
// [RL2] PRE-OP blinks run indicator continuously
// [RL3] SAFE-OP single flash and pause; outputs safe
// [RL4] operational state: run indicator solidly lit
// [RL5] bootstrap state: run indicator flickers
// [RL6] fault dark if none; blinks on config error
// [RL7] emergency change: fault single flash, pause
// [RL8] application watchdog: fault double flash, pause
// [RL9] interface watchdog expiry: fault solidly lit
// [RL10] boot failure: fault indicator flickers
// [RL11] leaving operational passes through safe state
// [RL12] safe state drives safe values, zero default
// [RL13] master-written safe values apply on later entries
// [RL14] free-running and synchronized cycle modes
// [RL15] free-run repeats at slowest module rate
// [RL16] free-run never faster than minimum cycle
// [RL17] synchronized cycles start only on event
// [RL18] error when imposed period too short
// [RL19] pattern periods are parameters; flicker faster
// [RL20] boot failure outranks watchdogs and config errors
`timescale 1ns/10ps
module fbs_status_cycle
  import fbs_pkg::*;
#(
  parameter int unsigned N_CH = 4,
  parameter int unsigned DW = 16,
  parameter int unsigned BLINK_C = BLINK_CYC,
  parameter int unsigned PAUSE_C = PAUSE_CYC,
  parameter int unsigned FLICKER_C = FLICKER_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic cycle_sync_i,
  output logic run_ind_o,
  output logic fault_ind_o,
  output logic [N_CH*DW-1:0] chan_out_o,
  output logic outputs_safe_o,
  output logic conv_start_o,
  output logic cycle_err_o
);
  if (N_CH < 1 || N_CH > 8 || DW < 1 || DW > 32) begin
    $error("fbs_status_cycle: N_CH must be 1..8 and DW 1..32");
  end

  typedef struct packed {
    logic ack;
    logic [31:0] rdat;
    fbs_state_t state;
    fbs_state_t pend;
    logic pend_v;
    logic sync_mode;
    logic [4:0] faults;
    logic cyc_err;
    logic [31:0] min_ns;
    logic [31:0] mod_per;
    logic [N_CH-1:0][DW-1:0] outv;
    logic [N_CH-1:0][DW-1:0] safe;
    logic [N_CH-1:0][DW-1:0] out;
    logic safe_flag;
    logic [31:0] cnt;
    logic conv;
    logic evt_prev;
    fbs_pat_t run_mode;
    fbs_pat_t fault_mode;
  } fbs_top_st_t;

  fbs_top_st_t s, n;
  logic evt_lvl;
  logic evt_edge;
  logic req;
  logic wr;
  logic ctrl_wr;
  logic active;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;
  logic [31:0] cw;
  logic [32:0] min_cyc;
  logic [31:0] per;
  logic [2:0] new_state;

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] dat,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction

  fbs_sync3 u_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .pin_i(cycle_sync_i),
    .lvl_o(evt_lvl)
  );

  // separate generators so run and fault patterns each keep their own phase counter
  fbs_blink #(
    .BLINK_C(BLINK_C),
    .PAUSE_C(PAUSE_C),
    .FLICKER_C(FLICKER_C)
  ) u_run (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mode_i(s.run_mode),
    .ind_o(run_ind_o)
  );

  fbs_blink #(
    .BLINK_C(BLINK_C),
    .PAUSE_C(PAUSE_C),
    .FLICKER_C(FLICKER_C)
  ) u_fault (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .mode_i(s.fault_mode),
    .ind_o(fault_ind_o)
  );

  always_comb begin
    ctrl_word = '0;
    ctrl_word[CTRL_STATE_LSB +: 3] = s.state;
    ctrl_word[CTRL_SYNC_BIT] = s.sync_mode;
    ctrl_word[CTRL_FAULT_LSB +: 5] = s.faults;
    stat_word = '0;
    stat_word[STAT_STATE_LSB +: 3] = s.state;
    stat_word[STAT_RUN_LSB +: 3] = s.run_mode;
    stat_word[STAT_CYCERR_BIT] = s.cyc_err;
    stat_word[STAT_SAFE_BIT] = s.safe_flag;
    stat_word[STAT_FAULT_LSB +: 3] = s.fault_mode;
  end

  assign req = wb_cyc_i & wb_stb_i & ~s.ack;
  assign wr = req & wb_we_i;
  assign ctrl_wr = wr && (wb_adr_i == REG_CTRL);
  assign cw = merge(ctrl_word, wb_dat_i, wb_sel_i);
  assign new_state = cw[CTRL_STATE_LSB +: 3];
  assign evt_edge = evt_lvl & ~s.evt_prev;
  assign active = (s.state == ST_SAFEOP) || (s.state == ST_OP);
  // round the minimum time up to whole clock cycles
  assign min_cyc = ({1'b0, s.min_ns} + 33'(CLK_NS - 1)) / 33'(CLK_NS);

  always_comb begin
    per = s.mod_per; // RL15
    if (min_cyc > {1'b0, per}) begin
      per = min_cyc[31:0]; // RL16
    end
    if (per == '0) begin
      per = 32'd1;
    end
  end

  always_comb begin
    n = s;
    n.ack = 1'b0;
    n.conv = 1'b0;
    n.evt_prev = evt_lvl;
    // second step of a two-step exit from operational
    if (s.pend_v) begin
      n.state = s.pend;
      n.pend_v = 1'b0;
    end
    if (req) begin
      n.ack = 1'b1;
      n.rdat = '0;
      case (wb_adr_i)
        REG_CTRL: n.rdat = ctrl_word;
        REG_STATUS: n.rdat = stat_word;
        REG_MIN_CYCLE: n.rdat = s.min_ns;
        REG_MOD_PERIOD: n.rdat = s.mod_per;
        default: begin
          for (int i = 0; i < N_CH; i++) begin
            if (wb_adr_i == REG_OUT_BASE + 8'(4 * i)) begin
              n.rdat = 32'(s.outv[i]);
            end
            if (wb_adr_i == REG_SAFE_BASE + 8'(4 * i)) begin
              n.rdat = 32'(s.safe[i]);
            end
          end
        end
      endcase
    end
    if (wr) begin
      case (wb_adr_i)
        REG_CTRL: begin
          n.sync_mode = cw[CTRL_SYNC_BIT]; // RL14
          n.faults = cw[CTRL_FAULT_LSB +: 5];
          if (new_state <= 3'(ST_BOOT)) begin
            if (s.state == ST_OP && new_state != 3'(ST_OP) &&
                new_state != 3'(ST_SAFEOP)) begin
              n.state = ST_SAFEOP; // RL11
              n.pend = fbs_state_t'(new_state);
              n.pend_v = 1'b1;
            end else begin
              n.state = fbs_state_t'(new_state);
              n.pend_v = 1'b0;
            end
          end
        end
        REG_STATUS: begin
          if (wb_sel_i[STAT_CYCERR_BIT / 8] && wb_dat_i[STAT_CYCERR_BIT]) begin
            n.cyc_err = 1'b0;
          end
        end
        REG_MIN_CYCLE: n.min_ns = merge(s.min_ns, wb_dat_i, wb_sel_i);
        REG_MOD_PERIOD: n.mod_per = merge(s.mod_per, wb_dat_i, wb_sel_i);
        default: begin
          for (int i = 0; i < N_CH; i++) begin
            if (wb_adr_i == REG_OUT_BASE + 8'(4 * i)) begin
              n.outv[i] = DW'(merge(32'(s.outv[i]), wb_dat_i, wb_sel_i));
            end
            if (wb_adr_i == REG_SAFE_BASE + 8'(4 * i)) begin
              n.safe[i] =
                DW'(merge(32'(s.safe[i]), wb_dat_i, wb_sel_i)); // RL13
            end
          end
        end
      endcase
    end
    // conversion cycle sequencing; the counter saturates when idle
    if (s.cnt != 32'hffff_ffff) begin
      n.cnt = s.cnt + 32'd1;
    end
    if (active) begin
      if (s.sync_mode) begin
        if (evt_edge) begin
          n.conv = 1'b1; // RL17
          n.cnt = '0;
          if (s.cnt < s.mod_per - 32'd1) begin
            n.cyc_err = 1'b1; // RL18
          end
        end
      end else if (s.cnt >= per - 32'd1) begin
        n.conv = 1'b1; // RL16
        n.cnt = '0;
      end
    end
    // outputs follow the application only when operational
    n.safe_flag = (s.state != ST_OP);
    n.out = (s.state == ST_OP) ? s.outv : s.safe; // RL12
    case (s.state)
      ST_INIT: n.run_mode = PAT_OFF; // RL1
      ST_PREOP: n.run_mode = PAT_BLINK; // RL2
      ST_SAFEOP: n.run_mode = PAT_SINGLE; // RL3
      ST_OP: n.run_mode = PAT_SOLID; // RL4
      ST_BOOT: n.run_mode = PAT_FLICKER; // RL5
      default: n.run_mode = PAT_OFF;
    endcase
    // highest-ranked fault wins the indicator
    if (s.faults[FLT_BOOT]) begin
      n.fault_mode = PAT_FLICKER; // RL10 RL20
    end else if (s.faults[FLT_PDI_WD]) begin
      n.fault_mode = PAT_SOLID; // RL9
    end else if (s.faults[FLT_APP_WD]) begin
      n.fault_mode = PAT_DOUBLE; // RL8
    end else if (s.faults[FLT_EMERG]) begin
      n.fault_mode = PAT_SINGLE; // RL7
    end else if (s.faults[FLT_CFG]) begin
      n.fault_mode = PAT_BLINK; // RL6
    end else begin
      n.fault_mode = PAT_OFF; // RL6
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.mod_per <= MOD_PERIOD_RST;
      s.min_ns <= MIN_CYCLE_RST;
      s.safe_flag <= 1'b1;
      s.cnt <= 32'hffff_ffff;
    end else if (ce_i) begin
      s <= n;
    end
  end

  assign wb_ack_o = s.ack;
  assign wb_dat_o = s.rdat;
  assign chan_out_o = s.out;
  assign outputs_safe_o = s.safe_flag;
  assign conv_start_o = s.conv;
  assign cycle_err_o = s.cyc_err;

  AST_RUN_INIT: assert property (@(posedge clk_i) disable iff (rst_i) // RL1
    ce_i && s.state == ST_INIT |=> s.run_mode == PAT_OFF)
    else $error("run indicator not dark in init");
  AST_RUN_PREOP: assert property (@(posedge clk_i) disable iff (rst_i) // RL2
    ce_i && s.state == ST_PREOP |=> s.run_mode == PAT_BLINK)
    else $error("run indicator not blinking in pre-op");
  AST_RUN_SAFEOP: assert property (@(posedge clk_i) disable iff (rst_i) // RL3
    ce_i && s.state == ST_SAFEOP |=> s.run_mode == PAT_SINGLE && s.safe_flag)
    else $error("safe-op indication or safe flag wrong");
  AST_RUN_OP: assert property (@(posedge clk_i) disable iff (rst_i) // RL4
    ce_i && s.state == ST_OP |=> s.run_mode == PAT_SOLID && !s.safe_flag)
    else $error("run indicator not solid in operational");
  AST_FAULT_PDI: assert property (@(posedge clk_i) disable iff (rst_i) // RL9
    ce_i && s.faults[FLT_PDI_WD] && !s.faults[FLT_BOOT]
    |=> s.fault_mode == PAT_SOLID)
    else $error("interface watchdog not solid");
  AST_FAULT_BOOT: assert property (@(posedge clk_i) disable iff (rst_i) // RL20
    ce_i && s.faults[FLT_BOOT] |=> s.fault_mode == PAT_FLICKER)
    else $error("boot failure not shown first");
  AST_SAFE_PASS: assert property (@(posedge clk_i) disable iff (rst_i) // RL11
    ce_i && s.state == ST_OP && ctrl_wr && new_state == 3'(ST_INIT)
    |=> s.state == ST_SAFEOP)
    else $error("operational left without safe state");
  AST_SAFE_OUT: assert property (@(posedge clk_i) disable iff (rst_i) // RL12
    ce_i && s.state != ST_OP |=> s.out == $past(s.safe))
    else $error("outputs not at safe values");
  AST_FREE_SPACE: assert property (@(posedge clk_i) disable iff (rst_i) // RL16
    ce_i && !s.sync_mode && s.cnt < per - 32'd1 |=> !s.conv)
    else $error("free-run cycle started too soon");
  AST_SYNC_ONLY: assert property (@(posedge clk_i) disable iff (rst_i) // RL17
    ce_i && s.sync_mode && !evt_edge |=> !s.conv)
    else $error("synchronized cycle without event");
  AST_SYNC_ERR: assert property (@(posedge clk_i) disable iff (rst_i) // RL18
    ce_i && active && s.sync_mode && evt_edge && s.cnt < s.mod_per - 32'd1
    |=> s.cyc_err && s.conv)
    else $error("short sync period not flagged");
endmodule

// *** tb/fbs_master_model.sv ***
/*
  Behavioural master side of the fieldbus: drives the cycle-start pin
  with a clean pulse of HOLD cycles per request.
  Assumes fire_i is a one-cycle request from the bench on clk_i.
*/
`timescale 1ns/10ps
module fbs_master_model #(
  parameter int unsigned HOLD = 4
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_i,
  output logic sync_o
);
  int unsigned cnt_q;
  // pulse kept well above the two-cycle filter of the synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt_q <= 0;
    end else if (fire_i) begin
      cnt_q <= HOLD;
    end else if (cnt_q != 0) begin
      cnt_q <= cnt_q - 1;
    end
  end
  // pin is actively driven low between events, no float
  assign sync_o = (cnt_q != 0);
endmodule

// *** tb/fbs_status_cycle_tb_top.sv ***
/*
  Self-checking bench for fbs_status_cycle: Wishbone tasks, indicator
  run-length checks, safe outputs and conversion cycle timing.
  Assumes fbs_pkg and the master model are compiled first.
*/
`timescale 1ns/10ps
module fbs_status_cycle_tb_top;
  import fbs_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic go = 1'b0;
  logic ce = 1'b1;
  logic [3:0] sel = 4'hf;
  logic sync_pin;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, run_ind_o, fault_ind_o, outputs_safe_o;
  logic conv_start_o, cycle_err_o;
  logic [63:0] chan_out_o;
  int mismatches = 0;
  int total_checks = 0;
  logic [31:0] q;
  int n, hi, lo;
  // short pattern periods keep the run small
  fbs_status_cycle #(.BLINK_C(8), .PAUSE_C(32),
    .FLICKER_C(2)) fbs_status_cycle_i (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .cycle_sync_i(sync_pin), .run_ind_o(run_ind_o),
    .fault_ind_o(fault_ind_o), .chan_out_o(chan_out_o),
    .outputs_safe_o(outputs_safe_o), .conv_start_o(conv_start_o),
    .cycle_err_o(cycle_err_o));
  fbs_master_model fbs_master_model_i (.clk_i(clk_i),
    .rst_i(rst_i), .fire_i(go), .sync_o(sync_pin));
  initial begin
    forever #4 clk_i = ~clk_i;
  end
  task automatic close_out;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && k < 50) begin
      k++;
      @(posedge clk_i);
    end
    if (k >= 50) chk(64'(wb_ack_o), 64'h1);
    q = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(64'(q), 64'(e));
  endtask
  function automatic logic [31:0] ctrl(input logic [2:0] s,
      input logic y, input logic [4:0] f);
    return {11'h0, f, 7'h0, y, 5'h0, s};
  endfunction
  // longest lit and dark runs over 96 cycles, longer than any period
  task automatic runs(input logic f, input int eh, input int el);
    int h, l;
    h = 0;
    l = 0;
    hi = 0;
    lo = 0;
    repeat (6) @(posedge clk_i);
    repeat (96) begin
      @(posedge clk_i);
      if ((f ? fault_ind_o : run_ind_o) === 1'b1) begin
        h++;
        l = 0;
      end else begin
        l++;
        h = 0;
      end
      if (h > hi) hi = h;
      if (l > lo) lo = l;
    end
    chk(64'(hi), 64'(eh));
    chk(64'(lo), 64'(el));
  endtask
  task automatic wait_conv(input int lim);
    n = 0;
    @(posedge clk_i);
    while (conv_start_o !== 1'b1 && n < lim) begin
      n++;
      @(posedge clk_i);
    end
  endtask
  task automatic fire;
    @(posedge clk_i);
    go <= 1'b1;
    @(posedge clk_i);
    go <= 1'b0;
  endtask
  initial begin
    #160000;
    mismatches++;
    close_out();
  end
  int rp[5] = '{0, 2, 3, 1, 5};
  int rh[5] = '{0, 8, 8, 96, 2};
  int rl[5] = '{96, 8, 32, 0, 2};
  logic [4:0] fv[8] = '{5'h01, 5'h02, 5'h04, 5'h08, 5'h10, 5'h1f,
                        5'h0c, 5'h00};
  int fp[8] = '{2, 3, 4, 1, 5, 5, 1, 0};
  int fh[8] = '{8, 8, 8, 96, 2, 2, 96, 0};
  int fl[8] = '{8, 32, 32, 0, 2, 2, 0, 96};
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    chk(chan_out_o, 64'h0);
    chk(64'(outputs_safe_o), 64'h1);
    rd(REG_STATUS, 32'h0000_0200);
    rd(REG_MOD_PERIOD, MOD_PERIOD_RST);
    rd(REG_MIN_CYCLE, MIN_CYCLE_RST);
    rd(8'hfc, 32'h0);
    sel <= 4'h1;
    wb(1'b1, REG_MIN_CYCLE, 32'hffff_ff11);
    sel <= 4'hf;
    rd(REG_MIN_CYCLE, 32'h0000_0011);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_OUT_BASE + 8'(4 * i), 32'ha5a0 + i);
    end
    wb(1'b1, REG_CTRL, ctrl(3'd2, 1'b0, 5'h0));
    repeat (3) @(posedge clk_i);
    chk(chan_out_o, 64'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, REG_SAFE_BASE + 8'(4 * i), 32'h5a50 + i);
    end
    wb(1'b1, REG_CTRL, ctrl(3'd3, 1'b0, 5'h0));
    repeat (3) @(posedge clk_i);
    chk(chan_out_o, 64'ha5a3_a5a2_a5a1_a5a0);
    chk(64'(outputs_safe_o), 64'h0);
    wb(1'b1, REG_CTRL, ctrl(3'd1, 1'b0, 5'h0));
    repeat (3) @(posedge clk_i);
    chk(chan_out_o, 64'h5a53_5a52_5a51_5a50);
    chk(64'(outputs_safe_o), 64'h1);
    for (int s = 0; s < 5; s++) begin
      wb(1'b1, REG_CTRL, ctrl(3'(s), 1'b0, 5'h0));
      runs(1'b0, rh[s], rl[s]);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(64'(q[6:4]), 64'(rp[s]));
    end
    for (int f = 0; f < 8; f++) begin
      wb(1'b1, REG_CTRL, ctrl(3'd3, 1'b0, fv[f]));
      runs(1'b1, fh[f], fl[f]);
      wb(1'b0, REG_STATUS, 32'h0);
      chk(64'(q[14:12]), 64'(fp[f]));
    end
    wb(1'b1, REG_CTRL, ctrl(3'd2, 1'b0, 5'h0));
    wb(1'b1, REG_MOD_PERIOD, 32'd20);
    wait_conv(200);
    wait_conv(200);
    chk(64'(n), 64'd19);
    // clock enable low must freeze the cycle sequencer
    ce <= 1'b0;
    wait_conv(40);
    chk(64'(n), 64'd40);
    ce <= 1'b1;
    wb(1'b1, REG_MIN_CYCLE, 32'd400);
    wait_conv(200);
    wait_conv(200);
    chk(64'(n), 64'd49);
    wb(1'b1, REG_MIN_CYCLE, 32'd100);
    wait_conv(200);
    wait_conv(200);
    chk(64'(n), 64'd19);
    wb(1'b1, REG_CTRL, ctrl(3'd3, 1'b1, 5'h0));
    wait_conv(100);
    chk(64'(n), 64'd100);
    fire();
    wait_conv(20);
    chk(64'(n < 20), 64'h1);
    repeat (60) @(posedge clk_i);
    fire();
    repeat (12) @(posedge clk_i);
    chk(64'(cycle_err_o), 64'h0);
    fire();
    repeat (8) @(posedge clk_i);
    fire();
    repeat (12) @(posedge clk_i);
    chk(64'(cycle_err_o), 64'h1);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(64'(q[8]), 64'h1);
    wb(1'b1, REG_STATUS, 32'h0000_0100);
    wb(1'b0, REG_STATUS, 32'h0);
    chk(64'(q[8]), 64'h0);
    close_out();
  end
endmodule
